// file: logic/vdst_host.sv
// host controller driving the transfer and serial pins of a video dram
// Function
// - transfer starts with transfer-enable low at row strobe fall.
// - column strobe, write enables and special-function pick transfer type.
// - after write then read, serial clock waits the transfer delay.
// - seamless reads need transfer-enable aligned with strobes and serial clock; the host makes none, serial clock is held through every non-split read cycle.
// - serial preload needs a masked write transfer with all mask bits low.
// - consecutive writes hold serial clock through the row cycle.
// - write-back keeps the top row bit of the preceding read.
// - wait the half-toggle delay before any split transfer.
// - a masked write transfer must precede split writes.
`timescale 1ns/1ns
module vdst_host
  import vdst_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // command side
  input wire logic cmd_valid,
  input wire vdst_cmd_t cmd,
  output logic cmd_ready,
  output logic cmd_err,
  output logic cmd_done,
  // serial stream side
  input wire logic ser_valid,
  input wire logic [DATA_W-1:0] ser_wdata,
  output logic ser_ready,
  output logic [DATA_W-1:0] ser_rdata,
  output logic ser_rvalid,
  output logic ser_is_input,
  // strobes and address pins
  output vdst_pins_t pins,
  // parallel data pins (mask only)
  output logic [DATA_W-1:0] dq_out,
  output logic dq_oe_n,
  // serial port pins
  output logic serial_clock,
  output logic serial_port_enable_n,
  output logic [DATA_W-1:0] serial_data_out,
  output logic serial_data_oe_n,
  input wire logic [DATA_W-1:0] serial_data_in,
  input wire logic half_status_out
);

  // ----------------------------------------------------------------
  // reset release and pin synchronisers
  // ----------------------------------------------------------------
  logic rst_s1_reg, rst_n_reg;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_s1_reg <= 1'b0;
      rst_n_reg <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_n_reg <= rst_s1_reg;
    end
  end

  logic qsf_s1_reg, qsf_s2_reg, qsf_s3_reg;
  logic [DATA_W-1:0] sdi_s1_reg, sdi_s2_reg;
  always_ff @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      qsf_s1_reg <= 1'b0;
      qsf_s2_reg <= 1'b0;
      qsf_s3_reg <= 1'b0;
      sdi_s1_reg <= 16'h0000;
      sdi_s2_reg <= 16'h0000;
    end else begin
      qsf_s1_reg <= half_status_out;
      qsf_s2_reg <= qsf_s1_reg;
      qsf_s3_reg <= qsf_s2_reg;
      sdi_s1_reg <= serial_data_in;
      sdi_s2_reg <= sdi_s1_reg;
    end
  end
  wire qsf_toggle = qsf_s2_reg ^ qsf_s3_reg;

  // ----------------------------------------------------------------
  // cycle sequencer
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_RAS, ST_COL, ST_CAS, ST_TRG, ST_PRE} vdst_st_t;
  vdst_st_t state_reg, state_next;
  vdst_cmd_t cmd_reg;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic conv_done_reg, last_conv_write_reg, have_read_reg, last_msb_reg;
  logic [CNT_W-1:0] sts_cnt_reg, hold_cnt_reg;
  logic ser_active_reg;
  logic port_in_reg;

  wire k_split = (cmd.kind == K_SPLIT_READ) || (cmd.kind == K_SPLIT_WRITE);
  wire k_cbr = (cmd_reg.kind == K_STOP_SET) || (cmd_reg.kind == K_REG_RESET);
  wire r_split = (cmd_reg.kind == K_SPLIT_READ) || (cmd_reg.kind == K_SPLIT_WRITE);
  wire r_wr = (cmd_reg.kind == K_WRITE) || (cmd_reg.kind == K_SPLIT_WRITE);
  // splits run alongside shifting; others wait for an idle serial word
  // split gating
  wire gate_ok = k_split ? (sts_cnt_reg == '0) : !ser_active_reg;
  wire take = cmd_valid && cmd_ready && gate_ok;
  wire bad_split = k_split && !conv_done_reg;
  wire bad_swr = (cmd.kind == K_SPLIT_WRITE) && !last_conv_write_reg;
  wire bad_msb = (cmd.kind == K_WRITE) && have_read_reg && (cmd.row[ROW_MSB] != last_msb_reg);
  wire illegal = bad_split || bad_swr || bad_msb || (cmd.kind > K_REG_RESET);
  wire cnt_zero = (cnt_reg == '0);

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_zero ? cnt_reg : cnt_reg - 1'b1;
    case (state_reg)
      ST_IDLE: if (take && !illegal) begin
        state_next = ST_SETUP;
        cnt_next = CNT_W'(STROBE_CYC);
      end
      ST_SETUP: if (cnt_zero) begin
        state_next = ST_RAS;
        cnt_next = CNT_W'(STROBE_CYC);
      end
      ST_RAS: if (cnt_zero) begin
        state_next = k_cbr ? ST_PRE : ST_COL;
        cnt_next = CNT_W'(STROBE_CYC);
      end
      ST_COL: if (cnt_zero) begin
        state_next = ST_CAS;
        cnt_next = CNT_W'(STROBE_CYC);
      end
      ST_CAS: if (cnt_zero) begin
        state_next = ST_TRG;
        cnt_next = CNT_W'(STROBE_CYC);
      end
      ST_TRG: if (cnt_zero) begin
        state_next = ST_PRE;
        cnt_next = CNT_W'(STROBE_CYC);
      end
      ST_PRE: if (cnt_zero) begin
        state_next = ST_IDLE;
      end
      default: state_next = ST_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // pin levels from the next state
  // ----------------------------------------------------------------
  wire n_act = (state_next != ST_IDLE) && (state_next != ST_PRE);
  wire n_ras = (state_next == ST_RAS) || (state_next == ST_COL) || (state_next == ST_CAS)
    || (state_next == ST_TRG);
  wire n_colph = (state_next == ST_COL) || (state_next == ST_CAS) || (state_next == ST_TRG);
  // the taken command owns the pins from its first setup cycle, no stale glitch
  vdst_cmd_t cur_cmd;
  assign cur_cmd = take ? cmd : cmd_reg;
  wire c_cbr = (cur_cmd.kind == K_STOP_SET) || (cur_cmd.kind == K_REG_RESET);
  wire c_split = (cur_cmd.kind == K_SPLIT_READ) || (cur_cmd.kind == K_SPLIT_WRITE);
  wire c_wr = (cur_cmd.kind == K_WRITE) || (cur_cmd.kind == K_SPLIT_WRITE);
  wire n_casl = c_cbr ? ((state_next == ST_SETUP) || (state_next == ST_RAS))
    : ((state_next == ST_CAS) || (state_next == ST_TRG));
  wire n_early = (state_next == ST_SETUP) || (state_next == ST_RAS);
  wire n_trgl = !c_cbr && n_act && (state_next != ST_TRG);
  wire n_wel = n_act && (c_wr || (cur_cmd.kind == K_STOP_SET));
  wire n_dsf = n_act && (c_split || (cur_cmd.kind == K_STOP_SET));
  wire n_dq = n_early && c_wr && !c_cbr;
  wire [DATA_W-1:0] mask_val = cur_cmd.mask_zero ? 16'h0000 : cur_cmd.mask;
  // start column, boundaries on row field
  wire [ADDR_W-1:0] n_addr = n_colph ? cur_cmd.col : cur_cmd.row;
  vdst_pins_t pins_next;
  assign pins_next = '{!n_ras, !n_casl, !n_trgl, !n_wel, !n_wel, n_dsf, n_addr};

  wire trg_rise = (state_reg != ST_TRG) && (state_next == ST_TRG);
  wire cas_fall = (state_reg != ST_CAS) && (state_next == ST_CAS);

  always_ff @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      state_reg <= ST_IDLE;
      cnt_reg <= '0;
      cmd_reg <= '0;
      pins <= PINS_IDLE;
      dq_out <= 16'h0000;
      dq_oe_n <= 1'b1;
      cmd_ready <= 1'b0;
      cmd_err <= 1'b0;
      cmd_done <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      if (take) cmd_reg <= cmd;
      pins <= pins_next;
      dq_out <= n_dq ? mask_val : 16'h0000;
      dq_oe_n <= !n_dq;
      cmd_ready <= (state_next == ST_IDLE) && !take;
      cmd_err <= take && illegal;
      cmd_done <= (state_reg == ST_PRE) && (state_next == ST_IDLE);
    end
  end

  // ----------------------------------------------------------------
  // transfer history and serial holds
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      conv_done_reg <= 1'b0;
      last_conv_write_reg <= 1'b0;
      have_read_reg <= 1'b0;
      last_msb_reg <= 1'b0;
      port_in_reg <= 1'b0;
      sts_cnt_reg <= '0;
      hold_cnt_reg <= '0;
    end else begin
      if (take && !illegal && (cmd.kind <= K_SPLIT_READ)) begin
        if (cmd.kind != K_SPLIT_READ) conv_done_reg <= 1'b1;
        if (cmd.kind != K_SPLIT_READ) last_conv_write_reg <= (cmd.kind == K_WRITE);
        if (cmd.kind != K_WRITE) begin
          have_read_reg <= 1'b1;
          last_msb_reg <= cmd.row[ROW_MSB];
        end
      end
      if (take && !illegal && (cmd.kind == K_READ)) port_in_reg <= 1'b0;
      else if (trg_rise && (cmd_reg.kind == K_WRITE)) port_in_reg <= 1'b1;
      if (qsf_toggle) sts_cnt_reg <= CNT_W'(STS_CYC);
      else if (sts_cnt_reg != '0) sts_cnt_reg <= sts_cnt_reg - 1'b1;
      if (trg_rise && (cmd_reg.kind == K_READ)) hold_cnt_reg <= CNT_W'(TSD_CYC);
      else if (cas_fall && (cmd_reg.kind == K_WRITE)) hold_cnt_reg <= CNT_W'(CSD_CYC);
      else if (hold_cnt_reg != '0) hold_cnt_reg <= hold_cnt_reg - 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // serial clock divider and word engine
  // ----------------------------------------------------------------
  // independent during splits; every other row cycle blocks
  // no seamless reads
  // a word may not start on the edge that takes a conventional transfer
  wire sc_block = ((state_reg != ST_IDLE) && !r_split) || (hold_cnt_reg != '0)
    || (take && !illegal && !k_split);
  logic [1:0] ph_reg;
  wire ser_start = !ser_active_reg && ser_valid && !sc_block;
  wire ph_last = ser_active_reg && (ph_reg == 2'h3);

  always_ff @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      ser_active_reg <= 1'b0;
      ph_reg <= 2'h0;
      serial_clock <= 1'b0;
      serial_port_enable_n <= 1'b1;
      serial_data_out <= 16'h0000;
      serial_data_oe_n <= 1'b1;
      ser_ready <= 1'b0;
      ser_rdata <= 16'h0000;
      ser_rvalid <= 1'b0;
      ser_is_input <= 1'b0;
    end else begin
      if (ser_start) ser_active_reg <= 1'b1;
      else if (ph_last) ser_active_reg <= 1'b0;
      ph_reg <= ser_active_reg ? ph_reg + 2'h1 : 2'h0;
      serial_clock <= ser_active_reg && (ph_reg != 2'h2) && (ph_reg != 2'h3);
      serial_port_enable_n <= 1'b0;
      if (ser_start && port_in_reg) serial_data_out <= ser_wdata;
      serial_data_oe_n <= !port_in_reg;
      ser_ready <= ser_start;
      if (ph_last && !port_in_reg) ser_rdata <= sdi_s2_reg;
      ser_rvalid <= ph_last && !port_in_reg;
      ser_is_input <= port_in_reg;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n_reg);

  // previous pin levels for the edge tests below
  logic ras_q_reg, sc_q_reg;
  always_ff @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      ras_q_reg <= 1'b1;
      sc_q_reg <= 1'b0;
    end else begin
      ras_q_reg <= pins.ras_n;
      sc_q_reg <= serial_clock;
    end
  end
  wire ras_fell = ras_q_reg && !pins.ras_n;
  wire sc_rose = !sc_q_reg && serial_clock;

  property p_trg_at_ras;
    ras_fell && (cmd_reg.kind <= K_SPLIT_WRITE) |-> !pins.transfer_enable_n;
  endproperty
  a_trg_at_ras: assert property (p_trg_at_ras) else $error("transfer enable high at ras fall");

  property p_read_decode;
    ras_fell && (cmd_reg.kind == K_READ) |-> pins.cas_n && pins.write_enable_low_byte_n
      && pins.write_enable_high_byte_n && !pins.special_function_in;
  endproperty
  a_read_decode: assert property (p_read_decode) else $error("bad read transfer decode");

  property p_split_decode;
    ras_fell && (cmd_reg.kind == K_SPLIT_READ) |-> pins.cas_n
      && pins.write_enable_low_byte_n && pins.special_function_in;
  endproperty
  a_split_decode: assert property (p_split_decode) else $error("bad split read decode");

  property p_tsd_hold;
    $rose(pins.transfer_enable_n) && (cmd_reg.kind == K_READ) |-> !sc_rose [*2];
  endproperty
  a_tsd_hold: assert property (p_tsd_hold) else $error("serial clock rose too soon after read");

  property p_write_hold;
    (state_reg != ST_IDLE) && (cmd_reg.kind == K_WRITE) |-> !sc_rose;
  endproperty
  a_write_hold: assert property (p_write_hold) else $error("serial clock during write cycle");

  property p_sts_wait;
    (state_reg == ST_SETUP) && ($past(state_reg) == ST_IDLE) && r_split
      |-> $past(sts_cnt_reg) == '0;
  endproperty
  a_sts_wait: assert property (p_sts_wait) else $error("split issued inside half toggle delay");

  property p_conv_first;
    ras_fell && r_split |-> conv_done_reg;
  endproperty
  a_conv_first: assert property (p_conv_first) else $error("split before conventional");

  property p_swr_after_wr;
    ras_fell && (cmd_reg.kind == K_SPLIT_WRITE) |-> last_conv_write_reg;
  endproperty
  a_swr_after_wr: assert property (p_swr_after_wr) else $error("split write without write");

  property p_zero_mask;
    ras_fell && r_wr && cmd_reg.mask_zero |-> !dq_oe_n && (dq_out == 16'h0000);
  endproperty
  a_zero_mask: assert property (p_zero_mask) else $error("preload mask not zero");

  property p_dir;
    $rose(pins.transfer_enable_n) && (cmd_reg.kind == K_WRITE)
      |-> ##1 (!serial_data_oe_n && ser_is_input);
  endproperty
  a_dir: assert property (p_dir) else $error("serial pins not driven after write");

endmodule : vdst_host

// file: logic/vdst_pkg.sv
// shared constants and types for the video dram transfer controller
package vdst_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int CNT_W = 8;
  localparam int STROBE_NS = 100;
  localparam int TRANSFER_TO_SERIAL_DELAY_NS = 20;
  localparam int COLUMN_TO_SERIAL_DELAY_NS = 20;
  localparam int HALF_TOGGLE_TO_TRANSFER_DELAY_NS = 30;

  // least times round up, never below one cycle
  function automatic int cyc_ceil(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction : cyc_ceil

  localparam int STROBE_CYC = cyc_ceil(STROBE_NS);
  localparam int TSD_CYC = cyc_ceil(TRANSFER_TO_SERIAL_DELAY_NS);
  localparam int CSD_CYC = cyc_ceil(COLUMN_TO_SERIAL_DELAY_NS);
  localparam int STS_CYC = cyc_ceil(HALF_TOGGLE_TO_TRANSFER_DELAY_NS);

  // ----------------------------------------------------------------
  // pin fields
  // ----------------------------------------------------------------
  localparam int ADDR_W = 9;
  localparam int DATA_W = 16;
  localparam int ROW_MSB = 8;

  typedef enum logic [2:0] {
    K_READ,
    K_WRITE,
    K_SPLIT_READ,
    K_SPLIT_WRITE,
    K_STOP_SET,
    K_REG_RESET
  } vdst_kind_t;

  typedef struct packed {
    vdst_kind_t kind;
    logic [ADDR_W-1:0] row;
    logic [ADDR_W-1:0] col;
    logic [DATA_W-1:0] mask;
    logic mask_zero;
  } vdst_cmd_t;

  typedef struct packed {
    logic ras_n;
    logic cas_n;
    logic transfer_enable_n;
    logic write_enable_low_byte_n;
    logic write_enable_high_byte_n;
    logic special_function_in;
    logic [ADDR_W-1:0] addr;
  } vdst_pins_t;

  localparam vdst_pins_t PINS_IDLE = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 9'h000};

endpackage : vdst_pkg

// file: dv/vdst_dram_model.sv
// behavioural video dram: transfer decode, row store and serial register
`timescale 1ns/1ns
module vdst_dram_model
  import vdst_pkg::*;
(
  // strobes and parallel pins
  input wire vdst_pins_t pins,
  input wire logic [DATA_W-1:0] dq_out,
  input wire logic dq_oe_n,
  // serial port
  input wire logic serial_clock,
  input wire logic serial_port_enable_n,
  input wire logic [DATA_W-1:0] serial_data_out,
  input wire logic serial_data_oe_n,
  output logic [DATA_W-1:0] serial_data_in,
  output logic half_status_out
);
  logic [DATA_W-1:0] ram [logic [17:0]];
  logic [DATA_W-1:0] sreg [512];
  logic [DATA_W-1:0] mask = 16'h0000;
  logic [DATA_W-1:0] last_q = 16'h0000;
  logic [ADDR_W-1:0] row = 9'h000;
  logic [ADDR_W-1:0] tap = 9'h000;
  logic [ADDR_W-1:0] ptr = 9'h000;
  logic out_mode = 1'b0;
  logic xfer = 1'b0;
  vdst_kind_t seen_kind = K_REG_RESET;
  logic [3:0] stops = 4'h0;
  logic stops_on = 1'b0;
  logic split_on = 1'b0;
  logic [ADDR_W-1:0] split_tap = 9'h000;
  int bad_clk = 0;

  // untouched rows read back as a pattern of row and column
  function automatic logic [DATA_W-1:0] rd(input logic [8:0] r, input logic [8:0] c);
    return ram.exists({r, c}) ? ram[{r, c}] : {r[6:0], c};
  endfunction : rd

  // decode and latch at row strobe fall
  always @(negedge pins.ras_n) begin
    row = pins.addr;
    mask = dq_oe_n ? 16'hFFFF : dq_out;
    xfer = !pins.transfer_enable_n;
    if (xfer && pins.cas_n) begin
      if (pins.write_enable_low_byte_n && pins.write_enable_high_byte_n)
        seen_kind = pins.special_function_in ? K_SPLIT_READ : K_READ;
      else
        seen_kind = pins.special_function_in ? K_SPLIT_WRITE : K_WRITE;
    end else if (!xfer && !pins.cas_n) begin
      seen_kind = pins.special_function_in ? K_STOP_SET : K_REG_RESET;
      if (pins.special_function_in) stops = pins.addr[7:4];
      stops_on = pins.special_function_in;
    end
  end

  // start position from column strobe fall
  always @(negedge pins.cas_n) begin
    if (xfer) tap = pins.addr;
  end

  always @(posedge pins.transfer_enable_n) begin
    if (xfer) begin
      for (int i = 0; i < 512; i++) begin
        logic [8:0] c;
        c = 9'(i);
        if (seen_kind == K_READ) sreg[i] = rd(row, c);
        if (seen_kind == K_WRITE) ram[{row, c}] = (rd(row, c) & ~mask) | (sreg[i] & mask);
        if (c[8] != ptr[8] && seen_kind == K_SPLIT_READ) sreg[i] = rd(row, c);
        if (c[8] != ptr[8] && seen_kind == K_SPLIT_WRITE)
          ram[{row, c}] = (rd(row, c) & ~mask) | (sreg[i] & mask);
      end
      if (seen_kind == K_READ || seen_kind == K_WRITE) begin
        out_mode = (seen_kind == K_READ);
        ptr = tap;
        split_on = 1'b0;
      end else begin
        // reloaded half starts at the given column's low eight bits in the other half
        split_on = 1'b1;
        split_tap = {~ptr[8], tap[7:0]};
      end
      xfer = 1'b0;
    end
  end

  // one word per serial rise, wrapping
  always @(posedge serial_clock) begin
    if (xfer && (seen_kind == K_READ || seen_kind == K_WRITE)) bad_clk++;
    if (!serial_port_enable_n) begin
      #1;
      if (out_mode) last_q = sreg[ptr];
      else sreg[ptr] = serial_data_out;
      if (split_on && ptr[7:0] == 8'hFF) begin
        ptr = split_tap;
        split_on = 1'b0;
      end else ptr = ptr + 9'h001;
    end
  end

  // released lines show the inverse of the last word
  assign serial_data_in = (out_mode && !serial_port_enable_n) ? last_q : ~last_q;
  // half status follows the active half
  assign half_status_out = ptr[8];
endmodule : vdst_dram_model

// file: dv/vdst_host_tb.sv
// self-checking bench for the video dram transfer controller
`timescale 1ns/1ns
module vdst_host_tb;
  import vdst_pkg::*;
  logic clk, reset_n, cmd_valid, ser_valid;
  vdst_cmd_t cmd;
  logic [DATA_W-1:0] ser_wdata, ser_rdata, dq_out, serial_data_out, serial_data_in;
  logic cmd_ready, cmd_err, cmd_done, ser_ready, ser_rvalid, ser_is_input;
  logic dq_oe_n, serial_clock, serial_port_enable_n, serial_data_oe_n, half_status_out;
  vdst_pins_t pins;
  int err_total = 0;
  int n_checks = 0;
  event hang_ev;

  vdst_host vdst_host_inst (.clk(clk), .reset_n(reset_n), .cmd_valid(cmd_valid), .cmd(cmd),
    .cmd_ready(cmd_ready), .cmd_err(cmd_err), .cmd_done(cmd_done), .ser_valid(ser_valid),
    .ser_wdata(ser_wdata), .ser_ready(ser_ready), .ser_rdata(ser_rdata),
    .ser_rvalid(ser_rvalid), .ser_is_input(ser_is_input), .pins(pins), .dq_out(dq_out),
    .dq_oe_n(dq_oe_n), .serial_clock(serial_clock),
    .serial_port_enable_n(serial_port_enable_n), .serial_data_out(serial_data_out),
    .serial_data_oe_n(serial_data_oe_n), .serial_data_in(serial_data_in),
    .half_status_out(half_status_out));

  vdst_dram_model vdst_dram_model_inst (.pins(pins), .dq_out(dq_out), .dq_oe_n(dq_oe_n),
    .serial_clock(serial_clock), .serial_port_enable_n(serial_port_enable_n),
    .serial_data_out(serial_data_out), .serial_data_oe_n(serial_data_oe_n),
    .serial_data_in(serial_data_in), .half_status_out(half_status_out));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic print_verdict;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict

  // a hung wait ends the run here, counted as a mismatch
  task automatic wait_hi(input string what, ref logic sig);
    int n;
    n = 0;
    while (sig !== 1'b1 && n < 60) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (sig !== 1'b1) begin
      err_total++;
      $display("wrong value %s expected 1 seen timeout", what);
      -> hang_ev;
    end
  endtask : wait_hi

  task automatic do_cmd(input vdst_kind_t k, input logic [8:0] r, input logic [8:0] c,
                        input logic [15:0] m, input logic exp_err);
    logic fin;
    int n;
    wait_hi("cmd_ready", cmd_ready);
    cmd = '{k, r, c, m, m == 16'h0000};
    cmd_valid = 1'b1;
    // held until the ready drop shows the take; gated commands wait here
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (cmd_ready === 1'b1 && n < 60);
    cmd_valid = 1'b0;
    fin = cmd_err | cmd_done;
    while (fin !== 1'b1 && n < 120) begin
      @(posedge clk);
      #1;
      n++;
      fin = cmd_err | cmd_done;
    end
    wait_hi("cmd_end", fin);
    check("cmd_err", cmd_err, exp_err);
  endtask : do_cmd

  task automatic ser_word(input logic [15:0] wd, input logic [15:0] exp, input logic chk);
    ser_wdata = wd;
    ser_valid = 1'b1;
    wait_hi("ser_ready", ser_ready);
    ser_valid = 1'b0;
    if (ser_is_input !== 1'b1) begin
      wait_hi("ser_rvalid", ser_rvalid);
      if (chk) check("ser_rdata", ser_rdata, exp);
    end else begin
      // one edge between words so valid is never set twice in a step
      @(posedge clk);
      #1;
    end
  endtask : ser_word

  task automatic t_read;
    do_cmd(K_SPLIT_READ, 9'h005, 9'h000, 16'hFFFF, 1'b1);
    do_cmd(K_READ, 9'h005, 9'h1FE, 16'hFFFF, 1'b0);
    check("kind", vdst_dram_model_inst.seen_kind, K_READ);
    check("ser_is_input", ser_is_input, 1'b0);
    for (int i = 0; i < 4; i++) ser_word(16'h0000, {7'h05, 9'h1FE + 9'(i)}, 1'b1);
  endtask : t_read

  task automatic t_refused;
    do_cmd(K_SPLIT_WRITE, 9'h005, 9'h000, 16'hFFFF, 1'b1);
    do_cmd(K_WRITE, 9'h105, 9'h000, 16'hFFFF, 1'b1);
  endtask : t_refused

  task automatic t_write;
    do_cmd(K_WRITE, 9'h007, 9'h000, 16'h0000, 1'b0);
    check("mask", vdst_dram_model_inst.mask, 16'h0000);
    check("kind", vdst_dram_model_inst.seen_kind, K_WRITE);
    check("ser_is_input", ser_is_input, 1'b1);
    for (int i = 0; i < 3; i++) ser_word(16'hA1C0 + 16'(i), 16'h0000, 1'b0);
    do_cmd(K_SPLIT_WRITE, 9'h007, 9'h000, 16'hFFFF, 1'b0);
    check("kind", vdst_dram_model_inst.seen_kind, K_SPLIT_WRITE);
    do_cmd(K_WRITE, 9'h007, 9'h000, 16'hFFFF, 1'b0);
    do_cmd(K_READ, 9'h007, 9'h000, 16'hFFFF, 1'b0);
    // preloaded words come back through the row
    for (int i = 0; i < 3; i++) ser_word(16'h0000, 16'hA1C0 + 16'(i), 1'b1);
  endtask : t_write

  task automatic t_split;
    do_cmd(K_SPLIT_READ, 9'h009, 9'h010, 16'hFFFF, 1'b0);
    check("kind", vdst_dram_model_inst.seen_kind, K_SPLIT_READ);
    check("ser_is_input", ser_is_input, 1'b0);
    // idle half reloaded from the new row
    for (int i = 3; i < 256; i++) ser_word(16'h0000, 16'h0000, 1'b0);
    ser_word(16'h0000, {7'h09, 9'h110}, 1'b1);
  endtask : t_split

  task automatic t_stops;
    do_cmd(K_STOP_SET, 9'h1A5, 9'h000, 16'hFFFF, 1'b0);
    check("stops", vdst_dram_model_inst.stops, 4'hA);
    check("stops_on", vdst_dram_model_inst.stops_on, 1'b1);
    do_cmd(K_REG_RESET, 9'h000, 9'h000, 16'hFFFF, 1'b0);
    check("kind", vdst_dram_model_inst.seen_kind, K_REG_RESET);
    check("stops_on", vdst_dram_model_inst.stops_on, 1'b0);
  endtask : t_stops

  initial begin
    @(hang_ev);
    print_verdict();
  end

  initial begin
    reset_n = 1'b0;
    cmd_valid = 1'b0;
    cmd = '0;
    ser_valid = 1'b0;
    ser_wdata = 16'h0000;
    repeat (8) @(posedge clk);
    check("pins", pins, PINS_IDLE);
    check("cmd_ready", cmd_ready, 1'b0);
    #1 reset_n = 1'b1;
    t_read();
    t_refused();
    t_write();
    t_split();
    t_stops();
    check("bad_clk", vdst_dram_model_inst.bad_clk, 0);
    print_verdict();
  end
endmodule : vdst_host_tb
